/* bench/tb_top.sv */
`timescale 1ns/1ps
`include "mcsw_defs.svh"
module tb_top;
  localparam int FAST_KHZ = 8000;
  localparam int HS_KHZ   = 10000;

  // Bench-driven inputs and observed outputs
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic                    cyc   = 1'b0;
  logic                    we    = 1'b0;
  logic [15:0]             adr   = 16'h0000;
  logic [3:0]              sel   = 4'h0;
  logic [31:0]             wdat  = 32'h00000000;
  logic [31:0]             rdat;
  logic [31:0]             rd;
  logic                    ack;
  logic                    fosc  = 1'b0;
  logic                    hosc  = 1'b0;
  logic [3:0]              fph   = 4'h0;
  logic [3:0]              hph   = 4'h0;
  int                      fedge = 0;
  int                      hedge = 0;
  int                      err_total = 0;
  int                      tests_run = 0;
  mcsw_pkg::mcsw_clk_ctl_s ctl;
  logic [7:0]              trim;

  mcsw_top #(.FAST_FREQ_KHZ(FAST_KHZ), .HS_FREQ_KHZ(HS_KHZ)) mcsw_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fast_osc_clk_i(fosc), .hs_sys_clk_i(hosc), .clk_ctl_o(ctl), .fast_osc_trim_o(trim)
  );

  // 50 MHz system clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  // Oscillator stand-ins, 8 and 10 clk periods, so each phase outlasts the synchroniser
  always @(posedge clk_i) begin
    fph <= (fph == 4'h7) ? 4'h0 : fph + 4'h1;
    hph <= (hph == 4'h9) ? 4'h0 : hph + 4'h1;
    if (fph == 4'h7) begin
      fosc  <= 1'b1;
      fedge <= fedge + 1;
    end
    if (fph == 4'h3) fosc <= 1'b0;
    if (hph == 4'h9) begin
      hosc  <= 1'b1;
      hedge <= hedge + 1;
    end
    if (hph == 4'h4) hosc <= 1'b0;
  end

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Classic cycle: hold everything until ack is seen at an edge, then one idle cycle
  task automatic wb_xfer(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    rd = rdat;
    cyc <= 1'b0;
    we  <= 1'b0;
    if (n >= 50) err_total++;
    @(posedge clk_i);
  endtask : wb_xfer

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d, 4'h1);
  endtask : wr

  task automatic chk_rd(input logic [15:0] a, input logic [31:0] e);
    wb_xfer(1'b0, a, 32'h0, 4'hF);
    check(rd, e);
  endtask : chk_rd

  // Start while the old source is low, so no rising edge is pending in the synchroniser
  task automatic switch_to(input logic hs, input int n_exp);
    int snap;
    int n;
    n = 0;
    while ((hs ? fph : hph) != 4'h5) @(posedge clk_i);
    snap = hs ? fedge : hedge;
    wr(`MCSW_ADR_MODE, {29'h0, 1'b1, 1'b0, hs});
    chk_rd(`MCSW_ADR_STAT, {28'h0, 1'b1, 1'b1, 1'b0, ~hs});
    while (ctl.main_hs !== hs && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) err_total++;
    check(32'((hs ? fedge : hedge) - snap), 32'(n_exp));
    chk_rd(`MCSW_ADR_STAT, {28'h0, 1'b1, 1'b0, 1'b0, hs});
  endtask : switch_to

  // Main sequence, reset applied twice to show the preselect lock clears
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({27'h0, ctl}, 32'h10);
    check({24'h0, trim}, 32'h10);
    chk_rd(`MCSW_ADR_TRIM, 32'h10);
    wb_xfer(1'b1, `MCSW_ADR_TRIM, 32'hA5, 4'h3);
    chk_rd(`MCSW_ADR_TRIM, 32'h10);
    wr(`MCSW_ADR_TRIM, 32'h5A);
    chk_rd(`MCSW_ADR_TRIM, 32'h5A);
    check({24'h0, trim}, 32'h5A);
    chk_rd(16'hFF40, 32'h0);
    wr(`MCSW_ADR_OSC, 32'h3);
    chk_rd(`MCSW_ADR_OSC, 32'h2);
    wr(`MCSW_ADR_MODE, 32'h1);
    repeat (40) @(posedge clk_i);
    chk_rd(`MCSW_ADR_STAT, 32'h0);
    wr(`MCSW_ADR_MODE, 32'h4);
    wr(`MCSW_ADR_MODE, 32'h0);
    chk_rd(`MCSW_ADR_MODE, 32'h4);
    chk_rd(`MCSW_ADR_STAT, 32'h8);
    wr(`MCSW_ADR_OSC, 32'h0);
    switch_to(1'b1, 1 + (2 * FAST_KHZ) / HS_KHZ);
    wr(`MCSW_ADR_OSC, 32'h3);
    chk_rd(`MCSW_ADR_OSC, 32'h1);
    check({27'h0, ctl}, 32'h0A);
    wr(`MCSW_ADR_MODE, 32'h4);
    chk_rd(`MCSW_ADR_STAT, 32'h9);
    wr(`MCSW_ADR_OSC, 32'h0);
    switch_to(1'b0, 1 + (2 * HS_KHZ) / FAST_KHZ);
    wr(`MCSW_ADR_OSC, 32'h2);
    chk_rd(`MCSW_ADR_OSC, 32'h2);
    wr(`MCSW_ADR_OSC, 32'h6);
    wr(`MCSW_ADR_OSC, 32'hE);
    chk_rd(`MCSW_ADR_STAT, 32'hA);
    wr(`MCSW_ADR_OSC, 32'hB);
    chk_rd(`MCSW_ADR_OSC, 32'hF);
    wr(`MCSW_ADR_OSC, 32'hE);
    wr(`MCSW_ADR_OSC, 32'h3);
    chk_rd(`MCSW_ADR_OSC, 32'h6);
    wr(`MCSW_ADR_OSC, 32'h6);
    wr(`MCSW_ADR_OSC, 32'h2);
    chk_rd(`MCSW_ADR_OSC, 32'h2);
    check({27'h0, ctl}, 32'h10);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_rd(`MCSW_ADR_MODE, 32'h0);
    wr(`MCSW_ADR_MODE, 32'h4);
    chk_rd(`MCSW_ADR_MODE, 32'h4);
    complete_run();
  end

  // Watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    complete_run();
  end
endmodule : tb_top

/* src/mcsw_defs.svh */
`ifndef MCSW_DEFS_SVH
`define MCSW_DEFS_SVH

// Register byte addresses
`define MCSW_ADR_TRIM        16'hFF30
`define MCSW_ADR_MODE        16'hFF34
`define MCSW_ADR_OSC         16'hFF38
`define MCSW_ADR_STAT        16'hFF3C

// Reset values
`define MCSW_TRIM_RST        8'h10
`define MCSW_SEL_RST         1'h0
`define MCSW_PRESEL_RST      1'h0
`define MCSW_FSTOP_RST       1'h0
`define MCSW_XSTOP_RST       1'h1
`define MCSW_SUBSEL_RST      1'h0
`define MCSW_CPUSUB_RST      1'h0

// Field positions, mode register
`define MCSW_MODE_SEL_BIT    0
`define MCSW_MODE_PRESEL_BIT 2
// Field positions, oscillator control register
`define MCSW_OSC_FSTOP_BIT   0
`define MCSW_OSC_XSTOP_BIT   1
`define MCSW_OSC_SUBSEL_BIT  2
`define MCSW_OSC_CPUSUB_BIT  3
// Field positions, status register
`define MCSW_STAT_MCS_BIT    0
`define MCSW_STAT_CLS_BIT    1
`define MCSW_STAT_BUSY_BIT   2
`define MCSW_STAT_LOCK_BIT   3

// Oscillator rates for the switch latency, in kHz, and the latency counter width in bits
`define MCSW_FAST_FREQ_KHZ   8000
`define MCSW_HS_FREQ_KHZ     10000
`define MCSW_CNT_W           8
`endif

/* src/mcsw_pkg.sv */
`include "mcsw_defs.svh"
package mcsw_pkg;
  typedef enum logic [0:0] {SW_IDLE, SW_WAIT} mcsw_sw_state_e;

  typedef logic [`MCSW_CNT_W-1:0] mcsw_cnt_t;

  // Oscillator enables and clock selects driven to the clock tree
  typedef struct packed {
    logic fast_en;
    logic x1_en;
    logic sub_en;
    logic main_hs;
    logic cpu_sub;
  } mcsw_clk_ctl_s;
endpackage : mcsw_pkg

/* src/mcsw_switch_timer.sv */
`timescale 1ns/1ps
module mcsw_switch_timer (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Control
  input  wire logic                start_i,
  input  wire logic                tick_i,
  input  wire mcsw_pkg::mcsw_cnt_t limit_i,
  // Status
  output logic                     busy_o,
  output logic                     done_o
);
  mcsw_pkg::mcsw_sw_state_e state_q;
  mcsw_pkg::mcsw_cnt_t      cnt_q;
  mcsw_pkg::mcsw_cnt_t      lim_q;
  mcsw_pkg::mcsw_cnt_t      seen_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Count edges of the old clock down to zero, then report done once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= mcsw_pkg::SW_IDLE;
      cnt_q   <= '0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_q)
        mcsw_pkg::SW_IDLE: begin
          if (start_i) begin
            state_q <= mcsw_pkg::SW_WAIT;
            cnt_q   <= limit_i;
          end
        end
        mcsw_pkg::SW_WAIT: begin
          if (tick_i) begin
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q <= 1) begin
              state_q <= mcsw_pkg::SW_IDLE;
              done_o  <= 1'b1;
            end
          end
        end
        default: state_q <= mcsw_pkg::SW_IDLE;
      endcase
    end
  end

  assign busy_o = (state_q == mcsw_pkg::SW_WAIT);

  // Checking aid: old-clock edges seen since the switch began
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lim_q  <= '0;
      seen_q <= '0;
    end else if (start_i && !busy_o) begin
      lim_q  <= limit_i;
      seen_q <= '0;
    end else if (busy_o && tick_i) begin
      seen_q <= seen_q + 1'b1;
    end
  end

  tick_count_a: assert property (done_o |-> seen_q == lim_q)
    else $error("switch ended after wrong number of old clocks");
  done_pulse_a: assert property (done_o |=> !done_o && !busy_o)
    else $error("done not a single pulse");
endmodule : mcsw_switch_timer

/* src/mcsw_top.sv */
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`include "mcsw_defs.svh"
module mcsw_top #(
  parameter int unsigned FAST_FREQ_KHZ = `MCSW_FAST_FREQ_KHZ,
  parameter int unsigned HS_FREQ_KHZ   = `MCSW_HS_FREQ_KHZ
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Wishbone classic slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [15:0]             wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // Oscillator clocks, sampled as levels
  input  wire logic                    fast_osc_clk_i,
  input  wire logic                    hs_sys_clk_i,
  // Clock tree control
  output mcsw_pkg::mcsw_clk_ctl_s      clk_ctl_o,
  output logic      [7:0]              fast_osc_trim_o
);
  // Truncating division drops the fraction of the latency figure
  localparam int unsigned TO_HS_CNT  = 1 + (2 * FAST_FREQ_KHZ) / HS_FREQ_KHZ;
  localparam int unsigned TO_INT_CNT = 1 + (2 * HS_FREQ_KHZ) / FAST_FREQ_KHZ;

  function automatic logic hit(input logic [15:0] adr, input logic [15:0] reg_adr);
    hit = (adr == reg_adr);
  endfunction : hit

  logic [2:0]          fast_sync_q;
  logic [2:0]          hs_sync_q;
  logic                fast_tick;
  logic                hs_tick;
  logic                bus_req;
  logic                wr_lo;
  logic                sel_q;
  logic                presel_q;
  logic                lock_q;
  logic                mcs_q;
  logic                fstop_q;
  logic                xstop_q;
  logic                subsel_q;
  logic                cls_q;
  logic                sw_busy;
  logic                sw_done;
  logic                sw_start;
  logic                sw_quiet;
  logic                stay_sub;
  logic                new_sel;
  mcsw_pkg::mcsw_cnt_t sw_limit;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Oscillator inputs: bit 0 feeds only bit 1, edges come from bits 1 and 2
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_sync_q <= 3'h0;
      hs_sync_q   <= 3'h0;
    end else begin
      fast_sync_q <= {fast_sync_q[1:0], fast_osc_clk_i};
      hs_sync_q   <= {hs_sync_q[1:0], hs_sys_clk_i};
    end
  end

  assign fast_tick = fast_sync_q[1] & ~fast_sync_q[2];
  assign hs_tick   = hs_sync_q[1] & ~hs_sync_q[2];

  // Bus strobes; every register lives in byte lane 0
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_lo   = bus_req & wb_we_i & wb_sel_i[0];
  assign new_sel = wb_dat_i[`MCSW_MODE_SEL_BIT];

  // The done cycle still counts as switching: status has not moved yet
  assign sw_quiet = !sw_busy && !sw_done;

  // A switch starts only when quiet and heading to a different source;
  // both main oscillators must run, since the old one clocks the count
  // and a stopped one would hang the timer; high speed also needs preselect
  assign sw_start = wr_lo && hit(wb_adr_i, `MCSW_ADR_MODE) && sw_quiet && (new_sel != mcs_q)
                    && !fstop_q && !xstop_q && (!new_sel || presel_q);

  // Latency and the clock counted both belong to the source in use
  assign sw_limit = mcs_q ? mcsw_pkg::mcsw_cnt_t'(TO_INT_CNT) : mcsw_pkg::mcsw_cnt_t'(TO_HS_CNT);

  mcsw_switch_timer u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (sw_start),
    .tick_i  (mcs_q ? hs_tick : fast_tick),
    .limit_i (sw_limit),
    .busy_o  (sw_busy),
    .done_o  (sw_done)
  );

  // Bus acknowledge, one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Trim register, single-byte writes to lane 0 only (select 4'h1)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_osc_trim_o <= `MCSW_TRIM_RST;
    end else if (bus_req && wb_we_i && hit(wb_adr_i, `MCSW_ADR_TRIM) && wb_sel_i == 4'h1) begin
      fast_osc_trim_o <= wb_dat_i[7:0];
    end
  end

  // Preselect: the first real change locks it until reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presel_q <= `MCSW_PRESEL_RST;
      lock_q   <= 1'b0;
    end else if (wr_lo && hit(wb_adr_i, `MCSW_ADR_MODE) && !lock_q
                 && wb_dat_i[`MCSW_MODE_PRESEL_BIT] != presel_q) begin
      presel_q <= wb_dat_i[`MCSW_MODE_PRESEL_BIT];
      lock_q   <= 1'b1;
    end
  end

  // Requested and active main source; status moves only at switch end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q <= `MCSW_SEL_RST;
      mcs_q <= `MCSW_SEL_RST;
    end else begin
      if (sw_start) begin
        sel_q <= new_sel;
      end
      if (sw_done) begin
        mcs_q <= sel_q;
      end
    end
  end

  // CPU counts as staying on the subclock only if this write keeps it there
  assign stay_sub = cls_q & wb_dat_i[`MCSW_OSC_CPUSUB_BIT];

  // Stop and select flags; a request that would stop the CPU clock is dropped,
  // also when it arrives in the same write that moves the CPU back to main
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fstop_q  <= `MCSW_FSTOP_RST;
      xstop_q  <= `MCSW_XSTOP_RST;
      subsel_q <= `MCSW_SUBSEL_RST;
      cls_q    <= `MCSW_CPUSUB_RST;
    end else if (wr_lo && hit(wb_adr_i, `MCSW_ADR_OSC)) begin
      if (!wb_dat_i[`MCSW_OSC_FSTOP_BIT] || ((mcs_q || stay_sub) && sw_quiet)) begin
        fstop_q <= wb_dat_i[`MCSW_OSC_FSTOP_BIT];
      end
      if (!wb_dat_i[`MCSW_OSC_XSTOP_BIT] || ((!mcs_q || stay_sub) && sw_quiet)) begin
        xstop_q <= wb_dat_i[`MCSW_OSC_XSTOP_BIT];
      end
      if (wb_dat_i[`MCSW_OSC_SUBSEL_BIT] || !(cls_q || wb_dat_i[`MCSW_OSC_CPUSUB_BIT])) begin
        subsel_q <= wb_dat_i[`MCSW_OSC_SUBSEL_BIT];
      end
      // CPU may leave the subclock only for a main source that still runs
      if (wb_dat_i[`MCSW_OSC_CPUSUB_BIT] ? subsel_q : (mcs_q ? !xstop_q : !fstop_q)) begin
        cls_q <= wb_dat_i[`MCSW_OSC_CPUSUB_BIT];
      end
    end
  end

  // Registered read data; unmapped addresses read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req) begin
      wb_dat_o <= 32'h0000_0000;
      if (hit(wb_adr_i, `MCSW_ADR_TRIM)) begin
        wb_dat_o[7:0] <= fast_osc_trim_o;
      end else if (hit(wb_adr_i, `MCSW_ADR_MODE)) begin
        wb_dat_o[`MCSW_MODE_SEL_BIT]    <= sel_q;
        wb_dat_o[`MCSW_MODE_PRESEL_BIT] <= presel_q;
      end else if (hit(wb_adr_i, `MCSW_ADR_OSC)) begin
        wb_dat_o[`MCSW_OSC_FSTOP_BIT]  <= fstop_q;
        wb_dat_o[`MCSW_OSC_XSTOP_BIT]  <= xstop_q;
        wb_dat_o[`MCSW_OSC_SUBSEL_BIT] <= subsel_q;
        wb_dat_o[`MCSW_OSC_CPUSUB_BIT] <= cls_q;
      end else if (hit(wb_adr_i, `MCSW_ADR_STAT)) begin
        wb_dat_o[`MCSW_STAT_MCS_BIT]  <= mcs_q;
        wb_dat_o[`MCSW_STAT_CLS_BIT]  <= cls_q;
        wb_dat_o[`MCSW_STAT_BUSY_BIT] <= sw_busy;
        wb_dat_o[`MCSW_STAT_LOCK_BIT] <= lock_q;
      end
    end
  end

  // Drive the clock tree from flops; both main sources run during a switch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_ctl_o <= '{fast_en: 1'b1, x1_en: 1'b0, sub_en: 1'b0, main_hs: 1'b0, cpu_sub: 1'b0};
    end else begin
      clk_ctl_o <= '{fast_en: !fstop_q, x1_en: !xstop_q, sub_en: subsel_q, main_hs: mcs_q, cpu_sub: cls_q};
    end
  end

  presel_once_a: assert property (lock_q |=> $stable(presel_q))
    else $error("preselect changed after lock");
  fstop_guard_a: assert property ($rose(fstop_q) |-> $past(mcs_q || cls_q))
    else $error("fast oscillator stopped while clocking cpu");
  xstop_guard_a: assert property ($rose(xstop_q) |-> $past(!mcs_q || cls_q))
    else $error("x1 stopped while clocking cpu");
  sub_guard_a: assert property ($fell(subsel_q) |-> $past(!cls_q))
    else $error("subclock deselected while clocking cpu");
  cpu_osc_run_a: assert property (!(cls_q ? !subsel_q : (mcs_q ? xstop_q : fstop_q)))
    else $error("cpu source oscillator stopped");
  trim_byte_a: assert property (bus_req && wb_we_i && wb_sel_i != 4'h1 |=> $stable(fast_osc_trim_o))
    else $error("trim written without byte access");
  status_follow_a: assert property (sw_done |=> mcs_q == sel_q ##1 clk_ctl_o.main_hs == mcs_q)
    else $error("main status did not follow select");
  hs_presel_a: assert property ($rose(mcs_q) |-> presel_q && !xstop_q)
    else $error("switched to high speed without preselect");
  switch_len_a: assert property ($rose(sw_busy) && !mcs_q |-> sw_busy[*1] ##0 $past(sw_limit) == TO_HS_CNT)
    else $error("wrong latency chosen");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  switch_run_a: assert property (sw_busy |-> !fstop_q && !xstop_q)
    else $error("main oscillator stopped during switch");
  sub_keep_a: assert property (cls_q |-> subsel_q)
    else $error("cpu on subclock while subclock deselected");
endmodule : mcsw_top
